// [rtl/ueb_top.sv]
// endpoint 1..3 buffer layout, toggles and handshake selection
// assumes: axi4-lite master for software; a serial engine that presents
// tokens and completions synchronous to aclk
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ueb_consts.svh"

// Operation
// RULE1: both directions off means endpoint unused
// RULE2: receive only single: one buffer at start
// RULE3: receive only dual: buffer by receive toggle
// RULE4: transmit only single: one buffer at start
// RULE5: transmit only dual: buffer by transmit toggle
// RULE6: both single: receive at start, transmit above
// RULE7: both dual: 256 bytes, offsets 0/64/128/192
// RULE8: start address low 15 bits, word aligned
// RULE9: software sizes receive buffers large enough
// RULE10: eight-bit transmit length per endpoint
// RULE11: control bit 7 expected out pid
// RULE12: control bit 6 sent in pid
// RULE13: bit 4 flips toggle after success
// RULE14: bits 3:2 select out handshake
// RULE15: bits 1:0 select in handshake
// RULE16: layout from receive, transmit, dual bits
// RULE17: pid mismatch is no success, no flip
module ueb_top
  import ueb_pkg::*;
#(
  parameter int NUM_EP = 3  // endpoints served, numbered from 1
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`UEB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`UEB_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   tok_valid,
  input  wire logic [1:0]             tok_ep,
  input  wire logic                   tok_in,
  output logic                        rsp_valid,
  output ueb_rsp_t                    rsp,
  input  wire logic                   cmp_valid,
  input  wire logic [1:0]             cmp_ep,
  input  wire logic                   cmp_in,
  input  wire logic                   cmp_ok,
  input  wire logic                   cmp_pid_data1
);

  // refuse sizes the two-bit endpoint field cannot reach; checked while
  // elaborating so a bad build never reaches simulation or synthesis
  if (NUM_EP < 1 || NUM_EP > 3) begin : g_num_ep_check
    $error("ueb_top: NUM_EP must be 1 to 3");
  end

  // write channel state
  logic                   aw_hold_q, aw_hold_d;  // address waiting
  logic [`UEB_ADDR_W-1:0] awaddr_q, awaddr_d;    // held write address
  logic                   w_hold_q, w_hold_d;    // data waiting
  logic [31:0]            wdata_q, wdata_d;      // held write data
  logic [3:0]             wstrb_q, wstrb_d;      // held byte lanes
  logic                   bvalid_q, bvalid_d;    // write answer pending
  logic [1:0]             bresp_q, bresp_d;      // write answer code
  // read channel state
  logic                   rvalid_q, rvalid_d;    // read answer pending
  logic [31:0]            rdata_q, rdata_d;      // read data
  logic [1:0]             rresp_q, rresp_d;      // read answer code
  // token answer state
  logic                   rsp_valid_q, rsp_valid_d;
  ueb_rsp_t               rsp_q, rsp_d;
  // endpoint register file, index 0 is endpoint 1
  ueb_ep_t                ep_q [NUM_EP];
  ueb_ep_t                ep_d [NUM_EP];

  // merged write view, taken this cycle or held earlier
  logic                   aw_take, w_take;
  logic                   aw_have, w_have, wr_fire;
  logic [`UEB_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   ar_take;

  // byte lane merge so a partial write keeps other lanes
  function automatic logic [15:0] lane16(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [1:0]  strb);
    lane16 = {strb[1] ? new_v[15:8] : old_v[15:8],
              strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // endpoint number is mapped when 1..NUM_EP
  function automatic logic ep_ok(input logic [1:0] n);
    ep_ok = (n != 2'h0) && ({30'h0, n} <= NUM_EP[31:0]);
  endfunction

  // buffer byte offset from the layout bits and direction
  function automatic logic [14:0] buf_off(input ueb_ep_t e,
                                          input logic    dir_in);
    logic [14:0] base;
    logic        tog;
    // receive, and transmit alone, sit at the start [RULE2] [RULE4]
    base = 15'h0000;
    tog  = dir_in ? e.ttog : e.rtog;
    if (dir_in && e.rx_en) begin
      // transmit sits above the receive part [RULE6] [RULE7]
      base = e.dual ? `UEB_TX_DUAL_BASE : `UEB_BUF_SIZE;
    end
    // second half picked by the toggle [RULE3] [RULE5] [RULE7]
    buf_off = base + ((e.dual && tog) ? `UEB_BUF_SIZE : 15'h0000);
  endfunction

  // handshakes are combinational off the state flops
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign aw_have       = aw_hold_q || aw_take;
  assign w_have        = w_hold_q || w_take;
  assign wr_fire       = aw_have && w_have;
  assign wr_addr       = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data       = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb       = w_hold_q ? wstrb_q : s_axi_wstrb;
  // no new write half while an answer waits: one write in flight
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rsp_valid     = rsp_valid_q;
  assign rsp           = rsp_q;

  // write channel next state, either order of address and data
  // an unmapped block still answers, so the master never hangs
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d  = awaddr_q;
    w_hold_d  = w_hold_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      // both halves present, commit and answer
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = ep_ok(wr_addr[5:4]) ? `UEB_RESP_OKAY : `UEB_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_hold_d = 1'b1;
        awaddr_d  = s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_d = 1'b1;
        wdata_d  = s_axi_wdata;
        wstrb_d  = s_axi_wstrb;
      end
    end
  end

  // read channel next state, answer one cycle after the address
  // unmapped blocks answer slverr with zero data, never a stale word
  always_comb begin
    ueb_ep_t e;
    e        = ep_q[0];
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0000_0000;
      rresp_d  = `UEB_RESP_SLVERR;
      if (ep_ok(s_axi_araddr[5:4])) begin
        e       = ep_q[s_axi_araddr[5:4] - 2'h1];
        rresp_d = `UEB_RESP_OKAY;
        case (s_axi_araddr[3:2])
          `UEB_REG_START: rdata_d = {16'h0000, e.start};
          `UEB_REG_TLEN:  rdata_d = {24'h000000, e.tlen};
          // reserved bit 5 reads zero; toggles show hardware flips
          `UEB_REG_CTRL:  rdata_d = {24'h000000, e.rtog, e.ttog, 1'b0,
                                     e.auto_tog, e.ores, e.ires};
          `UEB_REG_MODE:  rdata_d = {29'h0, e.rx_en, e.tx_en, e.dual};
          default:        rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // per endpoint register next values
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      always_comb begin
        logic       hit;
        logic [7:0] b0;
        // locals first so no path leaves them unassigned
        hit = wr_fire && (wr_addr[5:4] == 2'(gi + 1));
        b0  = wr_data[7:0];
        ep_d[gi] = ep_q[gi];
        if (hit) begin
          case (wr_addr[3:2])
            `UEB_REG_START: begin
              // bit 15 unused, bits 1:0 held zero for alignment [RULE8]
              ep_d[gi].start = lane16(ep_q[gi].start, wr_data[15:0],
                                      wr_strb[1:0]) & 16'h7ffc;
            end
            `UEB_REG_TLEN: begin
              if (wr_strb[0]) begin
                ep_d[gi].tlen = b0;  // [RULE10]
              end
            end
            `UEB_REG_CTRL: begin
              if (wr_strb[0]) begin
                ep_d[gi].rtog     = b0[`UEB_CTRL_RTOG];  // [RULE11]
                ep_d[gi].ttog     = b0[`UEB_CTRL_TTOG];  // [RULE12]
                ep_d[gi].auto_tog = b0[`UEB_CTRL_AUTO];
                ep_d[gi].ores = b0[`UEB_CTRL_ORES_HI:`UEB_CTRL_ORES_LO];
                ep_d[gi].ires = b0[`UEB_CTRL_IRES_HI:`UEB_CTRL_IRES_LO];
              end
            end
            `UEB_REG_MODE: begin
              if (wr_strb[0]) begin
                ep_d[gi].rx_en = b0[`UEB_MODE_RXEN];
                ep_d[gi].tx_en = b0[`UEB_MODE_TXEN];
                ep_d[gi].dual  = b0[`UEB_MODE_DUAL];
              end
            end
            default: begin
              ep_d[gi] = ep_q[gi];
            end
          endcase
        end
        // hardware flip lands on top of a same-cycle write
        // a completion for an unmapped endpoint matches no slot
        if (cmp_valid && cmp_ok && (cmp_ep == 2'(gi + 1)) &&
            ep_q[gi].auto_tog) begin
          if (cmp_in) begin
            ep_d[gi].ttog = !ep_d[gi].ttog;  // [RULE13]
          end else if (cmp_pid_data1 == ep_q[gi].rtog) begin
            // a pid mismatch is no reception and leaves it [RULE17]
            ep_d[gi].rtog = !ep_d[gi].rtog;  // [RULE13]
          end
        end
      end

      // endpoint register flops, toggles and modes clear on reset
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ep_q[gi] <= '{start: `UEB_RST_START, tlen: `UEB_RST_TLEN,
                        ores: UEB_HS_ACK, ires: UEB_HS_ACK,
                        default: 1'b0};
        end else begin
          ep_q[gi] <= ep_d[gi];
        end
      end
    end
  endgenerate

  // token answer: layout, address, length, pid and handshake
  always_comb begin
    ueb_ep_t e;
    logic    en;
    e           = ep_q[0];
    en          = 1'b0;
    rsp_valid_d = 1'b0;
    rsp_d       = rsp_q;
    if (tok_valid) begin
      rsp_valid_d = 1'b1;
      // unmapped endpoint falls through as a disabled direction
      if (ep_ok(tok_ep)) begin
        e  = ep_q[tok_ep - 2'h1];
        // layout chosen from all three mode bits [RULE16]
        en = tok_in ? e.tx_en : e.rx_en;
      end
      rsp_d.enabled = en;
      // a disabled direction uses no buffer, answers nothing [RULE1]
      rsp_d.addr  = en ? (e.start[14:0] + buf_off(e, tok_in)) // [RULE2]
                       : 15'h0000;                            // [RULE1]
      rsp_d.len   = (en && tok_in) ? e.tlen : 8'h00;
      rsp_d.data1 = en && tok_in && e.ttog;
      if (!en) begin
        rsp_d.hs = UEB_HS_NONE;
      end else if (tok_in) begin
        rsp_d.hs = ueb_hs_t'(e.ires);  // [RULE15]
      end else begin
        rsp_d.hs = ueb_hs_t'(e.ores);  // [RULE14]
      end
    end
  end

  // bus and answer flops
  // sync reset only: every reset branch loads constants
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q   <= 1'b0;
      awaddr_q    <= '0;
      w_hold_q    <= 1'b0;
      wdata_q     <= 32'h0000_0000;
      wstrb_q     <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_q     <= `UEB_RESP_OKAY;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      rresp_q     <= `UEB_RESP_OKAY;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '{hs: UEB_HS_NONE, default: '0};
    end else begin
      aw_hold_q   <= aw_hold_d;
      awaddr_q    <= awaddr_d;
      w_hold_q    <= w_hold_d;
      wdata_q     <= wdata_d;
      wstrb_q     <= wstrb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q       <= rsp_d;
    end
  end

endmodule // ueb_top
`default_nettype wire

// [rtl/ueb_consts.svh]
// offsets, field positions and reset values of the endpoint buffers
// assumes: included by bare name from the top module and the bench
`ifndef UEB_CONSTS_SVH
`define UEB_CONSTS_SVH
// register word inside an endpoint block, address bits [3:2]
`define UEB_REG_START      2'h0
`define UEB_REG_TLEN       2'h1
`define UEB_REG_CTRL       2'h2
`define UEB_REG_MODE       2'h3
// endpoint block number sits in address bits [5:4]
`define UEB_ADDR_W         6
// handshake control field positions
`define UEB_CTRL_RTOG      7
`define UEB_CTRL_TTOG      6
`define UEB_CTRL_AUTO      4
`define UEB_CTRL_ORES_HI   3
`define UEB_CTRL_ORES_LO   2
`define UEB_CTRL_IRES_HI   1
`define UEB_CTRL_IRES_LO   0
// mode register field positions
`define UEB_MODE_RXEN      2
`define UEB_MODE_TXEN      1
`define UEB_MODE_DUAL      0
// buffer layout offsets in bytes
`define UEB_BUF_SIZE       15'h0040
`define UEB_TX_DUAL_BASE   15'h0080
// reset values
`define UEB_RST_START      16'h0000
`define UEB_RST_TLEN       8'h00
// axi responses
`define UEB_RESP_OKAY      2'h0
`define UEB_RESP_SLVERR    2'h2
`endif

// [rtl/ueb_pkg.sv]
// types shared by the endpoint buffer block
// assumes: the constants header sits beside it
`default_nettype none
package ueb_pkg;
  // answer chosen for a token
  typedef enum logic [1:0] {
    UEB_HS_ACK   = 2'b00,
    UEB_HS_NONE  = 2'b01,
    UEB_HS_NAK   = 2'b10,
    UEB_HS_STALL = 2'b11
  } ueb_hs_t;

  // software state of one endpoint
  typedef struct packed {
    logic [15:0] start;    // buffer start address
    logic [7:0]  tlen;     // bytes to send on next in
    logic        rtog;     // expected receive toggle
    logic        ttog;     // transmit toggle
    logic        auto_tog; // toggle auto flip enable
    logic [1:0]  ores;     // out handshake select
    logic [1:0]  ires;     // in handshake select
    logic        rx_en;    // receive enable
    logic        tx_en;    // transmit enable
    logic        dual;     // dual buffer select
  } ueb_ep_t;

  // answer to a token
  typedef struct packed {
    logic        enabled;  // direction in use
    ueb_hs_t     hs;       // handshake
    logic [14:0] addr;     // buffer byte address
    logic [7:0]  len;      // bytes to send
    logic        data1;    // pid to send is data1
  } ueb_rsp_t;
endpackage
`default_nettype wire

// [dv/ueb_host_model.sv]
// host controller model: issues tokens and transaction completions
// assumes: tasks called from the bench, one request at a time
`timescale 1ns/10ps
`default_nettype none
module ueb_host_model (
  input  wire logic       aclk,
  output logic            tok_valid,
  output logic [1:0]      tok_ep,
  output logic            tok_in,
  output logic            cmp_valid,
  output logic [1:0]      cmp_ep,
  output logic            cmp_in,
  output logic            cmp_ok,
  output logic            cmp_pid_data1
);
  // idle fields carry the inverse of the last value, never a stale copy
  initial begin
    {tok_valid, tok_ep, tok_in} = '0;
    {cmp_valid, cmp_ep, cmp_in, cmp_ok, cmp_pid_data1} = '0;
  end
  // one token pulse, fields scrambled after
  task automatic tok(logic [1:0] e, logic i);
    @(posedge aclk);
    tok_valid <= 1'b1;
    {tok_ep, tok_in} <= {e, i};
    @(posedge aclk);
    tok_valid <= 1'b0;
    {tok_ep, tok_in} <= ~{e, i};
  endtask
  // one completion pulse; p is the pid seen on an out
  task automatic cmp(logic [1:0] e, logic i, logic ok, logic p);
    @(posedge aclk);
    cmp_valid <= 1'b1;
    {cmp_ep, cmp_in, cmp_ok, cmp_pid_data1} <= {e, i, ok, p};
    @(posedge aclk);
    cmp_valid <= 1'b0;
    {cmp_ep, cmp_in, cmp_ok, cmp_pid_data1} <= ~{e, i, ok, p};
  endtask
endmodule // ueb_host_model
`default_nettype wire

// [dv/ueb_top_asserts.sv]
// port checker for the endpoint buffer block
// assumes: bound into ueb_top, single clock aclk
`timescale 1ns/10ps
`default_nettype none
module ueb_top_asserts
  import ueb_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tok_valid,
  input wire logic        tok_in,
  input wire logic        rsp_valid,
  input wire ueb_rsp_t    rsp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // every token answered exactly one cycle later
  chk_tok_answer: assert property (tok_valid |=> rsp_valid)
    else $error("token not answered");
  chk_no_spurious: assert property (!tok_valid |=> !rsp_valid)
    else $error("answer without token");
  // unused direction must not point into memory
  chk_off_silent: assert property (rsp_valid && !rsp.enabled |->
    rsp.hs == UEB_HS_NONE && rsp.addr == 15'h0000)
    else $error("disabled direction answered");
  chk_addr_word: assert property (rsp_valid |-> rsp.addr[1:0] == 2'h0)
    else $error("buffer address not word aligned");
  chk_out_nolen: assert property (rsp_valid && !$past(tok_in) |->
    rsp.len == 8'h00)
    else $error("out answer carries a length");
  chk_rsp_holds: assert property (!tok_valid |=> $stable(rsp))
    else $error("answer changed without token");
  // bus answers held until taken
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read not answered");
endmodule // ueb_top_asserts
bind ueb_top ueb_top_asserts u_chk (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tok_valid, .tok_in,
  .rsp_valid, .rsp);
`default_nettype wire

// [dv/usb_device_endpoint_buffers_tb.sv]
// self-checking bench: axi register access, tokens, completions
// assumes: ueb_top, ueb_host_model and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
`include "ueb_consts.svh"
module usb_device_endpoint_buffers_tb;
  import ueb_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, v;
  logic [3:0] wstrb = '0;
  wire logic awready, wready, bvalid, arready, rvalid, rsp_valid;
  wire logic [1:0] bresp, rresp, tok_ep, cmp_ep;
  wire logic [31:0] rdata;
  wire logic tok_valid, tok_in, cmp_valid, cmp_in, cmp_ok, cmp_pd;
  wire ueb_rsp_t rsp;
  logic [31:0] sh [16];     // shadow of the register words
  logic [27:0] rq [$];      // expected answers, msb marks in
  logic [33:0] dq [$];      // expected read resp and data
  logic [1:0]  bq [$];      // expected write resp
  logic [27:0] n;
  logic [26:0] m;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  ueb_top #(.NUM_EP(3)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tok_valid(tok_valid), .tok_ep(tok_ep),
    .tok_in(tok_in), .rsp_valid(rsp_valid), .rsp(rsp),
    .cmp_valid(cmp_valid), .cmp_ep(cmp_ep), .cmp_in(cmp_in),
    .cmp_ok(cmp_ok), .cmp_pid_data1(cmp_pd));
  ueb_host_model host (.aclk(aclk), .tok_valid(tok_valid),
    .tok_ep(tok_ep), .tok_in(tok_in), .cmp_valid(cmp_valid),
    .cmp_ep(cmp_ep), .cmp_in(cmp_in), .cmp_ok(cmp_ok),
    .cmp_pid_data1(cmp_pd));
  // single comparison point
  task automatic check(string s, logic [33:0] got, logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // writable bits of each register word
  function automatic logic [31:0] msk(logic [1:0] r);
    case (r)
      2'h0: return 32'h7ffc;  // start: 15 bits, word aligned
      2'h1: return 32'h00ff;  // transmit length
      2'h2: return 32'h00df;  // control, bit 5 reserved
      default: return 32'h0007;
    endcase
  endfunction
  // expected token answer from the shadow
  function automatic ueb_rsp_t er(logic [1:0] e, logic i);
    ueb_rsp_t r;
    logic [31:0] c, md;
    c = sh[{e, 2'h2}];
    md = sh[{e, 2'h3}];
    r = '0;
    r.hs = UEB_HS_NONE;
    if (md[i ? 1 : 2]) begin  // direction enabled
      r.enabled = 1'b1;
      r.hs = ueb_hs_t'(i ? c[1:0] : c[3:2]);
      r.addr = sh[{e, 2'h0}][14:0]
        + ((i && md[2]) ? (md[0] ? 15'h80 : 15'h40) : 15'h0)
        + ((md[0] && c[i ? 6 : 7]) ? 15'h40 : 15'h0);
      r.len = i ? sh[{e, 2'h1}][7:0] : 8'h00;
      r.data1 = i & c[6];
    end
    return r;
  endfunction
  // s picks the byte lanes; lanes left out keep their old bits
  task automatic wr(logic [5:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
    logic ta, tw, b;
    logic [31:0] bm;
    ta = 0;
    tw = 0;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & msk(a[3:2]);
    bq.push_back(a[5:4] == 0 ? `UEB_RESP_SLVERR : `UEB_RESP_OKAY);
    if (a[5:4] != 0) sh[a[5:2]] = (sh[a[5:2]] & ~bm) | (d & bm);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ta && tw)) begin
      @(negedge aclk);
      if (awvalid && awready) ta = 1;
      if (wvalid && wready) tw = 1;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    do begin @(negedge aclk); b = bvalid; @(posedge aclk); end while (!b);
    bready <= 0;
  endtask
  task automatic rd(logic [5:0] a);
    logic b;
    dq.push_back({a[5:4] == 0 ? `UEB_RESP_SLVERR : `UEB_RESP_OKAY,
                  a[5:4] == 0 ? 32'h0 : sh[a[5:2]]});
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin @(negedge aclk); b = arready; @(posedge aclk); end while (!b);
    arvalid <= 0;
    do begin @(negedge aclk); b = rvalid; @(posedge aclk); end while (!b);
    rready <= 0;
  endtask
  task automatic tk(logic [1:0] e, logic i);
    rq.push_back({i, er(e, i)});
    host.tok(e, i);
  endtask
  // completion; shadow flips as the device should
  task automatic cp(logic [1:0] e, logic i, logic ok, logic p);
    if (sh[{e, 2'h2}][4] && ok && (i || p == sh[{e, 2'h2}][7]))
      sh[{e, 2'h2}][i ? 6 : 7] ^= 1'b1;
    host.cmp(e, i, ok, p);
  endtask
  // watcher: oldest note against each result as it shows
  always @(negedge aclk) begin
    if (rsp_valid === 1'b1) begin
      n = rq.pop_front();
      m = n[27] ? 27'h7ffffff : 27'h7fffffe;  // out pid bit left out of the compare
      check("rsp", 34'(rsp & m), 34'(n[26:0] & m));
    end
    if (rvalid === 1'b1 && rready)
      check("rd", {rresp, rdata}, dq.pop_front());
    if (bvalid === 1'b1 && bready)
      check("bresp", 34'(bresp), 34'(bq.pop_front()));
  end
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    v = $urandom(32'h8586aac2);
    foreach (sh[i]) sh[i] = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int a = 0; a < 64; a += 4) rd(a[5:0]);
    $display("test reset values done");
    for (int a = 0; a < 64; a += 4) begin
      wr(a[5:0], $urandom);
      rd(a[5:0]);
      wr(a[5:0], $urandom, 4'($urandom));
      rd(a[5:0]);
    end
    $display("test register access done");
    for (int e = 1; e < 4; e++) for (int k = 0; k < 32; k++) begin
      wr({e[1:0], 4'h0}, $urandom & 32'h7f00);  // 256 apart
      wr({e[1:0], 4'h8}, ($urandom & 32'hc0) | {k[4:3], k[4:3]});
      wr({e[1:0], 4'hc}, 32'(k[2:0]));
      tk(e[1:0], 1'b0);
      tk(e[1:0], 1'b1);
    end
    tk(2'h0, 1'b1);
    $display("test layout and handshake done");
    for (int e = 1; e < 4; e++) begin
      wr({e[1:0], 4'h8}, 32'h10);
      cp(e[1:0], 1'b1, 1'b1, 1'b0);
      cp(e[1:0], 1'b0, 1'b1, 1'b0);
      cp(e[1:0], 1'b0, 1'b1, 1'b0);
      cp(e[1:0], 1'b1, 1'b0, 1'b0);
      rd({e[1:0], 4'h8});
      tk(e[1:0], 1'b1);
      wr({e[1:0], 4'h8}, 32'h00);
      cp(e[1:0], 1'b1, 1'b1, 1'b0);
      rd({e[1:0], 4'h8});
    end
    $display("test toggle flip done");
    repeat (4) @(posedge aclk);
    check("queued", 34'(rq.size() + dq.size() + bq.size()), 0);
    end_of_test();
  end
endmodule // usb_device_endpoint_buffers_tb
`default_nettype wire
